// >>> motion_filter.sv
// speed filter or moving average on the commanded step rate, per ms tick
`timescale 1ns/100ps
module motion_filter #(
  parameter int W   = 20,
  parameter int TCW = 8
) (
  input  wire logic           mclk_i,
  input  wire logic           sys_rst_i,
  input  wire logic           tick_i,
  input  wire logic           sel_i,
  input  wire logic [TCW-1:0] sf_tc_i,
  input  wire logic [TCW-1:0] ma_tc_i,
  input  wire logic [W-1:0]   din_i,
  output logic      [W-1:0]   dout_o
);
  localparam int DEPTH = 1 << TCW;
  logic [W+TCW-1:0] hist [DEPTH];
  logic [TCW-1:0]   wp;
  logic [W+TCW-1:0] total;
  logic [W+TCW-1:0] next_total;
  logic [W+TCW-1:0] next_sum;
  logic [TCW-1:0]   tc;
  logic             bypass;
  logic             up;
  logic [W-1:0]     mag;
  logic             run_ma;
  logic             run_up;
  logic             div_done;
  logic [31:0]      quo;
  logic [W-1:0]     step;

  assign tc       = sel_i ? ma_tc_i : sf_tc_i;
  assign bypass   = (tc == '0);
  assign next_total = total + (W+TCW)'(din_i);
  // window sum is the difference of two running totals; wraps cancel out
  assign next_sum = next_total - hist[wp - ma_tc_i];
  assign up       = din_i >= dout_o;
  assign mag      = up ? din_i - dout_o : dout_o - din_i;
  assign step     = (quo == 32'h0) ? W'(1) : quo[W-1:0];

  // history holds running totals in both selections, so a switch or a new
  // averaging time gives a correct window from the next tick on
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wp    <= '0;
      total <= '0;
      for (int i = 0; i < DEPTH; i++)
        hist[i] <= '0;
    end else if (tick_i) begin
      hist[wp] <= next_total;
      wp       <= wp + 1'b1;
      total    <= next_total;
    end
  end

  seq_divider #(.WIDTH(32)) u_div (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i  (tick_i && !bypass),
    .num_i    (sel_i ? 32'(next_sum) : 32'(mag)),
    .den_i    (32'(tc)),
    .done_o   (div_done),
    .quo_o    (quo)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dout_o <= '0;
      run_ma <= 1'b0;
      run_up <= 1'b0;
    end else if (tick_i) begin
      run_ma <= sel_i;
      run_up <= up;
      if (bypass)
        dout_o <= din_i;
    end else if (div_done) begin
      if (run_ma)
        dout_o <= quo[W-1:0];
      else if (dout_o != din_i)
        dout_o <= run_up ? dout_o + step : dout_o - step;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_filter_bypass: assert property (tick_i && bypass |=> dout_o == $past(din_i))
    else $error("zero time constant did not bypass the filter");
  chk_ma_select: assert property (tick_i && !bypass && sel_i |->
    ##34 dout_o == $past(next_sum, 34) / 32'($past(ma_tc_i, 34)))
    else $error("moving average output wrong");
endmodule : motion_filter

// >>> motor_winding_model.sv
// motor winding model: tracks shaft position from step and direction
`timescale 1ns/100ps
module motor_winding_model (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         step_i,
  input  wire logic         dir_i,
  output logic signed [31:0] position_o
);
  // each high cycle of the pulse is one step; direction high counts up
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      position_o <= '0;
    end else if (step_i) begin
      position_o <= dir_i ? position_o + 1 : position_o - 1;
    end
  end
endmodule : motor_winding_model

// >>> seq_divider.sv
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module seq_divider #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] num_i,
  input  wire logic [WIDTH-1:0] den_i,
  output logic                  done_o,
  output logic      [WIDTH-1:0] quo_o
);
  localparam int CW = $clog2(WIDTH + 1);
  logic [WIDTH:0]   rem;
  logic [WIDTH-1:0] den;
  logic [CW-1:0]    cnt;
  logic [WIDTH:0]   shifted;
  logic [WIDTH:0]   trial;

  assign shifted = {rem[WIDTH-1:0], quo_o[WIDTH-1]};
  assign trial   = shifted - {1'b0, den};

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rem    <= '0;
      den    <= '0;
      quo_o  <= '0;
      cnt    <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        rem   <= '0;
        den   <= den_i;
        quo_o <= num_i;
        cnt   <= CW'(WIDTH);
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1))
          done_o <= 1'b1;
        if (!trial[WIDTH]) begin
          rem   <= trial;
          quo_o <= {quo_o[WIDTH-2:0], 1'b1};
        end else begin
          rem   <= shifted;
          quo_o <= {quo_o[WIDTH-2:0], 1'b0};
        end
      end
    end
  end
endmodule : seq_divider

// >>> stepper_consts.svh
// constants for the stepper motion profile block: timing, widths, map, resets
`ifndef STEPPER_CONSTS_SVH
`define STEPPER_CONSTS_SVH

`define CLK_NS        8
`define CLK_HZ        (1000000000 / `CLK_NS)
`define MS_NS         1000000
`define TICK_CYCLES   (`MS_NS / `CLK_NS)
`define RATE_NUM      32'h000f4240

`define SPD_W         20
`define ACC_W         20
`define CUR_W         10
`define TC_W          8
`define TRV_W         23
`define PHASE_W       27

`define OFF_RUN_CUR   8'h00
`define OFF_STOP_CUR  8'h04
`define OFF_SF_TC     8'h08
`define OFF_MA_TC     8'h0c
`define OFF_FILT_SEL  8'h10
`define OFF_COM_ACC   8'h14
`define OFF_COM_DEC   8'h18
`define OFF_START_SPD 8'h1c
`define OFF_JOG_SPD   8'h20
`define OFF_JOG_ACC   8'h24
`define OFF_JOG_START 8'h28
`define OFF_ACC_TYPE  8'h2c
`define OFF_ACC_UNIT  8'h30
`define OFF_JOG_TRV   8'h34
`define OFF_STATUS    8'h38

`define RST_RUN_CUR   10'h3e8
`define RST_STOP_CUR  10'h1f4
`define RST_TC        8'h01
`define RST_SEL       1'h0
`define RST_ACC       20'h07530
`define RST_START_SPD 20'h00064
`define RST_JOG_SPD   20'h003e8
`define RST_TYPE      1'h1
`define RST_UNIT      1'h0
`define RST_TRAVEL    23'h000001

`define MAX_RUN_CUR   32'h000003e8
`define MAX_STOP_CUR  32'h000001f4
`define MAX_TC        32'h000000c8
`define MAX_SPD       32'h000f4240
`define MAX_TRAVEL    32'h007fffff

`endif

// >>> stepper_motion_profile_params.sv
// stepper motion profile: apb settings, ramp, filter, step pulses, current
`include "stepper_consts.svh"
`timescale 1ns/100ps
module stepper_motion_profile_params
  import stepper_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                cmd_start_i,
  input  wire logic                cmd_link_i,
  input  wire logic                cmd_stop_i,
  input  wire logic [1:0]          cmd_mode_i,
  input  wire logic                cmd_dir_i,
  input  wire logic [`TRV_W-1:0]   cmd_distance_i,
  input  wire logic [`SPD_W-1:0]   run_speed_value_i,
  input  wire logic [`ACC_W-1:0]   op_accel_i,
  input  wire logic [`ACC_W-1:0]   op_decel_i,
  output logic                     step_o,
  output logic                     dir_o,
  output logic                     moving_o,
  output logic [`CUR_W-1:0]        current_limit_o,
  output logic [`SPD_W-1:0]        speed_o
);
  localparam int TW = $clog2(TICK_CYCLES);

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic [`SPD_W-1:0] max_spd(input logic [`SPD_W-1:0] a,
                                                input logic [`SPD_W-1:0] b);
    max_spd = (a > b) ? a : b;
  endfunction : max_spd

  logic [`CUR_W-1:0] run_cur;
  logic [`CUR_W-1:0] stop_cur;
  logic [`TC_W-1:0]  sf_tc;
  logic [`TC_W-1:0]  ma_tc;
  logic              filt_sel;
  logic [`ACC_W-1:0] com_acc;
  logic [`ACC_W-1:0] com_dec;
  logic [`SPD_W-1:0] start_spd;
  logic [`SPD_W-1:0] jog_spd;
  logic [`ACC_W-1:0] jog_acc;
  logic [`SPD_W-1:0] jog_start;
  logic              acc_type;
  logic              acc_unit;
  logic [`TRV_W-1:0] jog_travel;

  // ---------------- apb slave, zero wait states ----------------
  logic        setup;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] next_prdata;
  logic [31:0] wd;

  assign setup   = psel_i && !penable_i;
  assign wr_en   = psel_i && penable_i && pready_o && pwrite_i;
  assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i <= `OFF_STATUS);
  assign wd      = pwdata_i;

  always_comb begin
    next_prdata = 32'h0;
    case (paddr_i)
      `OFF_RUN_CUR:   next_prdata = 32'(run_cur);
      `OFF_STOP_CUR:  next_prdata = 32'(stop_cur);
      `OFF_SF_TC:     next_prdata = 32'(sf_tc);
      `OFF_MA_TC:     next_prdata = 32'(ma_tc);
      `OFF_FILT_SEL:  next_prdata = 32'(filt_sel);
      `OFF_COM_ACC:   next_prdata = 32'(com_acc);
      `OFF_COM_DEC:   next_prdata = 32'(com_dec);
      `OFF_START_SPD: next_prdata = 32'(start_spd);
      `OFF_JOG_SPD:   next_prdata = 32'(jog_spd);
      `OFF_JOG_ACC:   next_prdata = 32'(jog_acc);
      `OFF_JOG_START: next_prdata = 32'(jog_start);
      `OFF_ACC_TYPE:  next_prdata = 32'(acc_type);
      `OFF_ACC_UNIT:  next_prdata = 32'(acc_unit);
      `OFF_JOG_TRV:   next_prdata = 32'(jog_travel);
      `OFF_STATUS:    next_prdata = {11'h0, moving_o, speed_o};
      default:        next_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && !addr_ok;
      if (setup)
        prdata_o <= next_prdata;
    end
  end

  // out of range writes saturate to the nearest legal value; the one-bit settings take bit 0 of the write
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_cur    <= `RST_RUN_CUR;
      stop_cur   <= `RST_STOP_CUR;
      sf_tc      <= `RST_TC;
      ma_tc      <= `RST_TC;
      filt_sel   <= `RST_SEL;
      com_acc    <= `RST_ACC;
      com_dec    <= `RST_ACC;
      start_spd  <= `RST_START_SPD;
      jog_spd    <= `RST_JOG_SPD;
      jog_acc    <= `RST_ACC;
      jog_start  <= `RST_START_SPD;
      acc_type   <= `RST_TYPE;
      acc_unit   <= `RST_UNIT;
      jog_travel <= `RST_TRAVEL;
    end else if (wr_en) begin
      case (paddr_i)
        `OFF_RUN_CUR:   run_cur    <= `CUR_W'(clamp(wd, 32'h0, `MAX_RUN_CUR));
        `OFF_STOP_CUR:  stop_cur   <= `CUR_W'(clamp(wd, 32'h0, `MAX_STOP_CUR));
        `OFF_SF_TC:     sf_tc      <= `TC_W'(clamp(wd, 32'h0, `MAX_TC));
        `OFF_MA_TC:     ma_tc      <= `TC_W'(clamp(wd, 32'h0, `MAX_TC));
        `OFF_FILT_SEL:  filt_sel   <= wd[0];
        `OFF_COM_ACC:   com_acc    <= `ACC_W'(clamp(wd, 32'h1, `MAX_SPD));
        `OFF_COM_DEC:   com_dec    <= `ACC_W'(clamp(wd, 32'h1, `MAX_SPD));
        `OFF_START_SPD: start_spd  <= `SPD_W'(clamp(wd, 32'h0, `MAX_SPD));
        `OFF_JOG_SPD:   jog_spd    <= `SPD_W'(clamp(wd, 32'h1, `MAX_SPD));
        `OFF_JOG_ACC:   jog_acc    <= `ACC_W'(clamp(wd, 32'h1, `MAX_SPD));
        `OFF_JOG_START: jog_start  <= `SPD_W'(clamp(wd, 32'h0, `MAX_SPD));
        `OFF_ACC_TYPE:  acc_type   <= wd[0];
        `OFF_ACC_UNIT:  acc_unit   <= wd[0];
        `OFF_JOG_TRV:   jog_travel <= `TRV_W'(clamp(wd, 32'h1, `MAX_TRAVEL));
        default:        ;
      endcase
    end
  end

  // ---------------- 1 ms profile tick ----------------
  logic [TW-1:0] tick_cnt;
  logic          tick;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // ---------------- ramp generator ----------------
  ramp_state_t       state;
  move_mode_t        mode;
  logic [`SPD_W-1:0] vel;
  logic [`SPD_W-1:0] tgt;
  logic [`SPD_W-1:0] floor_spd;
  logic [`ACC_W-1:0] acc_l;
  logic [`ACC_W-1:0] dec_l;
  logic [`TRV_W-1:0] remaining;
  logic              is_jog;
  logic              start_new;
  logic              start_link;
  logic              braking;
  logic              div_go;
  logic              div_done;
  logic [31:0]       div_num;
  logic [31:0]       quo;
  logic [`SPD_W-1:0] dv;
  logic [`SPD_W-1:0] sel_floor;

  assign is_jog     = cmd_mode_i[1];
  assign sel_floor  = is_jog ? jog_start : start_spd;
  assign start_new  = cmd_start_i && (state == ST_IDLE);
  assign start_link = cmd_start_i && cmd_link_i && (state == ST_RUN)
                      && !mode[1];
  assign braking    = (state == ST_DECEL) || (vel > tgt);
  assign div_go     = tick && (state != ST_IDLE);
  // rate unit: 1 kHz per n us is 1e6/n Hz per ms; time unit: span/n per ms
  assign div_num    = acc_unit ? 32'(tgt - floor_spd) : `RATE_NUM;
  assign dv         = (quo == 32'h0) ? `SPD_W'(1)
                      : ((quo > `MAX_SPD) ? `SPD_W'(`MAX_SPD) : quo[`SPD_W-1:0]);

  seq_divider #(.WIDTH(32)) u_ramp_div (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i  (div_go),
    .num_i    (div_num),
    .den_i    (32'(braking ? dec_l : acc_l)),
    .done_o   (div_done),
    .quo_o    (quo)
  );

  // move setup; a linked step keeps the acceleration of the chain's head
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode      <= MODE_POS;
      dir_o     <= 1'b0;
      tgt       <= '0;
      floor_spd <= '0;
      acc_l     <= `RST_ACC;
      dec_l     <= `RST_ACC;
    end else if (start_new || start_link) begin
      mode      <= move_mode_t'(cmd_mode_i);
      dir_o     <= cmd_dir_i;
      floor_spd <= sel_floor;
      tgt       <= max_spd(is_jog ? jog_spd : run_speed_value_i,
                           sel_floor);
      if (start_new && is_jog) begin
        acc_l <= jog_acc;
        dec_l <= jog_acc;
      end else if (start_new && !acc_type) begin
        acc_l <= com_acc;
        dec_l <= com_dec;
      end else if (start_new) begin
        acc_l <= (op_accel_i == '0) ? `ACC_W'(1) : op_accel_i;
        dec_l <= (op_decel_i == '0) ? `ACC_W'(1) : op_decel_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      vel   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_new) begin
            state <= ST_RUN;
            vel   <= sel_floor;
          end
        end
        ST_RUN: begin
          if (cmd_stop_i) begin
            state <= ST_DECEL;
          end else if (mode != MODE_CONT && mode != MODE_JOG_CONT
                       && remaining == '0 && !start_link) begin
            state <= ST_IDLE;
            vel   <= '0;
          end else if (start_link) begin
            vel <= max_spd(vel, sel_floor);
          end else if (div_done && vel < tgt) begin
            vel <= (tgt - vel > dv) ? vel + dv : tgt;
          end else if (div_done && vel > tgt) begin
            vel <= (vel - tgt > dv) ? vel - dv : max_spd(tgt, floor_spd);
          end
        end
        ST_DECEL: begin
          if (div_done) begin
            if (vel <= floor_spd || vel - floor_spd <= dv) begin
              state <= ST_IDLE;
              vel   <= '0;
            end else begin
              vel <= vel - dv;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          vel   <= '0;
        end
      endcase
    end
  end

  // ---------------- filter, step pulses, current ----------------
  logic [`SPD_W-1:0]   fspd;
  logic [`PHASE_W-1:0] phase;
  logic [`PHASE_W-1:0] next_phase;

  motion_filter #(.W(`SPD_W), .TCW(`TC_W)) u_filter (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i   (tick),
    .sel_i    (filt_sel),
    .sf_tc_i  (sf_tc),
    .ma_tc_i  (ma_tc),
    .din_i    (vel),
    .dout_o   (fspd)
  );

  assign next_phase = phase + `PHASE_W'(fspd);

  // pulses stop as soon as the move ends, even while the filter still decays
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phase  <= '0;
      step_o <= 1'b0;
    end else if (state == ST_IDLE) begin
      phase  <= '0;
      step_o <= 1'b0;
    end else begin
      step_o <= next_phase >= `PHASE_W'(`CLK_HZ);
      phase  <= (next_phase >= `PHASE_W'(`CLK_HZ))
                ? next_phase - `PHASE_W'(`CLK_HZ) : next_phase;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      remaining <= '0;
    end else if (start_new || start_link) begin
      remaining <= (cmd_mode_i == MODE_JOG_STEP) ? jog_travel
                   : cmd_distance_i;
    end else if (step_o && remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      moving_o        <= 1'b0;
      speed_o         <= '0;
      current_limit_o <= `RST_STOP_CUR;
    end else begin
      moving_o        <= state != ST_IDLE;
      speed_o         <= fspd;
      current_limit_o <= (state != ST_IDLE) ? run_cur : stop_cur;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  chk_run_current: assert property (state != ST_IDLE |=> current_limit_o == $past(run_cur))
    else $error("run current not applied while moving");
  chk_stop_current: assert property (state == ST_IDLE |=> current_limit_o == $past(stop_cur))
    else $error("standstill current not applied");
  chk_start_floor: assert property (state == ST_RUN |-> vel >= floor_spd && tgt >= floor_spd)
    else $error("speed below starting speed");
  chk_common_accel: assert property (start_new && !is_jog && !acc_type |=> acc_l == $past(com_acc) && dec_l == $past(com_dec))
    else $error("common acceleration not selected");
  chk_link_accel: assert property (start_link |=> $stable(acc_l) && $stable(dec_l))
    else $error("linked step changed acceleration");
  chk_rate_unit: assert property (div_go && !acc_unit |-> div_num == `RATE_NUM)
    else $error("rate unit numerator wrong");
  chk_jog_launch: assert property (start_new && is_jog |=> vel == $past(jog_start) && tgt == max_spd($past(jog_spd), $past(jog_start)))
    else $error("jog start or run speed wrong");
  chk_jog_accel: assert property (start_new && is_jog |=> acc_l == $past(jog_acc) ##1 acc_l == $past(acc_l))
    else $error("jog acceleration not latched");
  chk_jog_travel: assert property (start_new && cmd_mode_i == MODE_JOG_STEP |=> remaining == $past(jog_travel))
    else $error("jog travel not loaded");
  chk_speed_ceiling: assert property (state == ST_RUN && vel <= tgt
    && !start_link |=> vel <= tgt || state != ST_RUN)
    else $error("speed overshot the target");
endmodule : stepper_motion_profile_params

// >>> stepper_motion_profile_params_tb.sv
// self-checking bench for the stepper motion profile block
`include "stepper_consts.svh"
`timescale 1ns/100ps
module stepper_motion_profile_params_tb;
  logic              mclk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, rdata;
  logic              pready, pslverr, rerr;
  logic              cmd_start = 1'b0, cmd_link = 1'b0, cmd_stop = 1'b0;
  logic [1:0]        cmd_mode = 2'h0;
  logic              cmd_dir = 1'b0;
  logic [22:0]       cmd_distance = 23'h000010;
  logic [19:0]       run_speed = 20'h00010;
  logic [19:0]       op_accel = 20'h00001, op_decel = 20'h00001;
  logic              step, dir, moving;
  logic [9:0]        cur;
  logic [19:0]       speed;
  logic signed [31:0] position, pos0;
  int                mismatches = 0, checked = 0;

  always #4 mclk_i = ~mclk_i;

  stepper_motion_profile_params #(.TICK_CYCLES(64))
    stepper_motion_profile_params_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cmd_start_i(cmd_start), .cmd_link_i(cmd_link),
    .cmd_stop_i(cmd_stop), .cmd_mode_i(cmd_mode), .cmd_dir_i(cmd_dir),
    .cmd_distance_i(cmd_distance), .run_speed_value_i(run_speed),
    .op_accel_i(op_accel), .op_decel_i(op_decel), .step_o(step),
    .dir_o(dir), .moving_o(moving), .current_limit_o(cur),
    .speed_o(speed));

  motor_winding_model motor_winding_model_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .step_i(step),
    .dir_i(dir), .position_o(position));

  task automatic bad(input string msg);
    mismatches++;
    $display("BAD t=%0t %s", $time, msg);
  endtask : bad

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // request held until the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 50) bad("no pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd

  task automatic wait_moving(input logic lvl);
    int n;
    n = 0;
    while (moving !== lvl && n < 20000) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 20000) bad("moving wait");
  endtask : wait_moving

  task automatic start(input logic [1:0] m, input logic d);
    @(posedge mclk_i);
    cmd_start <= 1'b1;
    cmd_mode <= m;
    cmd_dir <= d;
    @(posedge mclk_i);
    cmd_start <= 1'b0;
  endtask : start

  task automatic halt;
    @(posedge mclk_i);
    cmd_stop <= 1'b1;
    @(posedge mclk_i);
    cmd_stop <= 1'b0;
    wait_moving(1'b0);
  endtask : halt

  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge mclk_i);
    bad("watchdog");
    results();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(`OFF_RUN_CUR, `RST_RUN_CUR);
    rd(`OFF_STOP_CUR, `RST_STOP_CUR);
    rd(`OFF_FILT_SEL, `RST_SEL);
    rd(`OFF_SF_TC, `RST_TC);
    rd(`OFF_MA_TC, `RST_TC);
    rd(`OFF_START_SPD, `RST_START_SPD);
    rd(`OFF_COM_ACC, `RST_ACC);
    rd(`OFF_COM_DEC, `RST_ACC);
    rd(`OFF_ACC_TYPE, `RST_TYPE);
    rd(`OFF_ACC_UNIT, `RST_UNIT);
    rd(`OFF_JOG_SPD, `RST_JOG_SPD);
    rd(`OFF_JOG_START, `RST_START_SPD);
    rd(`OFF_JOG_ACC, `RST_ACC);
    rd(`OFF_JOG_TRV, `RST_TRAVEL);
    $display("test reset values done");
    // out-of-range settings saturate to the nearest legal value
    wr(`OFF_RUN_CUR, 32'h000007d0);
    rd(`OFF_RUN_CUR, `MAX_RUN_CUR);
    wr(`OFF_STOP_CUR, 32'h00000258);
    rd(`OFF_STOP_CUR, `MAX_STOP_CUR);
    wr(`OFF_SF_TC, 32'h0000012c);
    rd(`OFF_SF_TC, `MAX_TC);
    wr(`OFF_COM_ACC, 32'h00000000);
    rd(`OFF_COM_ACC, 32'h00000001);
    wr(`OFF_JOG_START, 32'h00100000);
    rd(`OFF_JOG_START, `MAX_SPD);
    wr(`OFF_JOG_TRV, 32'h00000000);
    rd(`OFF_JOG_TRV, 32'h00000001);
    wr(`OFF_ACC_UNIT, 32'h00000001);
    rd(`OFF_ACC_UNIT, 32'h00000001);
    wr(`OFF_ACC_UNIT, 32'h00000000);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdata, 32'h0);
    wr(`OFF_STATUS, 32'hffffffff);
    rd(`OFF_STATUS, 32'h00000000);
    $display("test saturation and map done");
    // jog step at full speed so the run stays short
    wr(`OFF_SF_TC, 32'h00000000);
    wr(`OFF_JOG_SPD, `MAX_SPD);
    wr(`OFF_JOG_TRV, 32'h00000005);
    wr(`OFF_RUN_CUR, 32'h000002bc);
    wr(`OFF_STOP_CUR, 32'h0000012c);
    repeat (2) @(posedge mclk_i);
    chk({22'h0, cur}, 32'h0000012c);
    start(2'h2, 1'b1);
    wait_moving(1'b1);
    chk({22'h0, cur}, 32'h000002bc);
    wait_moving(1'b0);
    chk(position, 32'h00000005);
    chk({22'h0, cur}, 32'h0000012c);
    $display("test jog step done");
    // commanded speed below the floor runs at the floor
    wr(`OFF_FILT_SEL, 32'h00000001);
    wr(`OFF_MA_TC, 32'h00000000);
    wr(`OFF_START_SPD, `MAX_SPD);
    start(2'h1, 1'b0);
    wait_moving(1'b1);
    repeat (800) @(posedge mclk_i);
    chk({12'h0, speed}, `MAX_SPD);
    rd(`OFF_STATUS, 32'h001f4240);
    halt();
    if (position >= 32'sh5) bad("no reverse travel");
    chk({22'h0, cur}, 32'h0000012c);
    $display("test continuous floor done");
    // filters start from a zero history so the ramp-in can be seen
    repeat (400) @(posedge mclk_i);
    wr(`OFF_SF_TC, 32'h00000004);
    wr(`OFF_FILT_SEL, 32'h00000000);
    start(2'h1, 1'b1);
    wait_moving(1'b1);
    repeat (200) @(posedge mclk_i);
    chk(32'(speed != 20'h0 && speed < 20'hf4240), 32'h1);
    repeat (4000) @(posedge mclk_i);
    chk({12'h0, speed}, `MAX_SPD);
    halt();
    wr(`OFF_MA_TC, 32'h00000004);
    wr(`OFF_FILT_SEL, 32'h00000001);
    repeat (400) @(posedge mclk_i);
    start(2'h3, 1'b0);
    wait_moving(1'b1);
    repeat (200) @(posedge mclk_i);
    chk(32'(speed != 20'h0 && speed < 20'hf4240), 32'h1);
    repeat (400) @(posedge mclk_i);
    chk({12'h0, speed}, `MAX_SPD);
    halt();
    $display("test filters done");
    pos0 = position;
    start(2'h0, 1'b1);
    wait_moving(1'b1);
    wait_moving(1'b0);
    chk(position - pos0, 32'h00000010);
    $display("test positioning done");
    results();
  end
endmodule : stepper_motion_profile_params_tb

// >>> stepper_pkg.sv
// types shared by the stepper motion profile block
package stepper_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DECEL = 3'b100
  } ramp_state_t;

  typedef enum logic [1:0] {
    MODE_POS      = 2'h0,
    MODE_CONT     = 2'h1,
    MODE_JOG_STEP = 2'h2,
    MODE_JOG_CONT = 2'h3
  } move_mode_t;
endpackage : stepper_pkg
